// File: bdc_regs.sv
// Functional notes
// - select 0 gives sim removal from a fixed three-tick debounce filter.
// - select 1 makes sim removal equal the main battery removal signal.
// - main removal debounced by 5-bit count, reset 10111, on undivided slow oscillator.
// - detection register bit 6 low enables detection; resets to 1.
// - detection register bit 7 low enables strong pull-up; resets to 0.
// - low battery reads 1 when below threshold, input valid, wireless invalid.
// - suspend bit 2 disables input; else limit from high bit, field, select.
// - with field select 0, bit 3 chooses 100mA or 500mA input limit.
// - with field select 1, high bit ignored, limit from 6-bit field.
// - bit 7 of charger register high disables the charge timer; resets 0.
// - effective termination voltage clamped by 4-bit ceiling, reset 1111.
`timescale 1ns/1ps
`include "bdc_defs.svh"

module bdc_regs
  import bdc_pkg::*;
(
  // clock and reset
  input  wire logic       SYS_CLK,
  input  wire logic       RST,
  // register port from the serial interface
  input  wire logic [7:0] REG_ADDR,
  input  wire logic [7:0] REG_WDATA,
  input  wire logic       REG_WR,
  input  wire logic       REG_RD,
  output logic      [7:0] REG_RDATA,
  output logic            REG_RVALID,
  // analog and oscillator pins
  input  wire logic       OSC_100K,
  input  wire logic       BAT_ABSENT,
  input  wire logic       MBATT_BELOW_PQ,
  input  wire logic       DC_VALID,
  input  wire logic       WC_VALID,
  // settings from neighbouring registers
  input  wire logic       ILIM_FIELD_SEL,
  input  wire logic [5:0] ILIM_FIELD,
  input  wire logic [3:0] VREG_CODE,
  // control outputs
  output logic            BATTERY_REMOVAL_SIGNAL,
  output logic            SIM_REMOVED,
  output logic            DET_EN,
  output logic            PULLUP_EN,
  output logic            DC_INPUT_ON,
  output logic            ILIM_500MA,
  output logic            ILIM_USE_FIELD,
  output logic      [5:0] ILIM_FIELD_OUT,
  output logic            CHG_TIMER_EN,
  output logic      [3:0] VTERM_EFF
);

  localparam int NPIN = `BDC_NPIN;

  logic [NPIN-1:0] pin_vec;
  logic [NPIN-1:0] s1_r;
  logic [NPIN-1:0] s2_r;
  logic [NPIN-1:0] s3_r;
  logic [NPIN-1:0] q_r;
  logic            osc_prev_r;
  logic            tick;
  logic            sim_sel_r;
  logic [4:0]      deb_cnt_r;
  logic            det_dis_r;
  logic            pu_dis_r;
  logic            susp_r;
  logic            hi_r;
  logic            tdis_r;
  logic [3:0]      ceil_r;
  logic            battery_below_prequal_flag_r;
  logic            battery_below_prequal_flag_nxt;
  bdc_sel_e        wsel;
  bdc_sel_e        rsel;
  bdc_byte_t       rd_mux;
  logic [3:0]      vclamp;

  bdc_deb_if #(.W(`BDC_CNT_W)) main_if ();
  bdc_deb_if #(.W(`BDC_CNT_W)) sim_if ();

  // address decoder shared by write and read paths
  function automatic bdc_sel_e addr_sel(input logic [7:0] a);
    case (a)
      `BDC_OFS_DET:   addr_sel = BDC_SEL_DET;
      `BDC_OFS_CHG:   addr_sel = BDC_SEL_CHG;
      `BDC_OFS_VCEIL: addr_sel = BDC_SEL_VCEIL;
      default:        addr_sel = BDC_SEL_NONE;
    endcase
  endfunction

  // pins: three flops then an output flop, a change counts once stages two and three agree
  assign pin_vec = {OSC_100K, BAT_ABSENT, MBATT_BELOW_PQ, DC_VALID, WC_VALID};

  generate
    for (genvar i = 0; i < NPIN; i++)
    begin : g_sync
      always_ff @(posedge SYS_CLK)
      begin
        if (RST)
        begin
          s1_r[i] <= 1'b0;
          s2_r[i] <= 1'b0;
          s3_r[i] <= 1'b0;
          q_r[i]  <= 1'b0;
        end
        else
        begin
          s1_r[i] <= pin_vec[i];
          s2_r[i] <= s1_r[i];
          s3_r[i] <= s2_r[i];
          if (s2_r[i] == s3_r[i])
            q_r[i] <= s3_r[i];
        end
      end
    end
  endgenerate

  // slow tick on each rising oscillator edge, one system cycle wide
  always_ff @(posedge SYS_CLK)
  begin
    if (RST)
      osc_prev_r <= 1'b0;
    else
      osc_prev_r <= q_r[4];
  end
  assign tick = q_r[4] & ~osc_prev_r;

  // decode and combinational selection
  assign wsel        = addr_sel(REG_ADDR);
  assign rsel        = addr_sel(REG_ADDR);
  assign battery_below_prequal_flag_nxt = q_r[2] & q_r[1] & ~q_r[0];
  assign vclamp      = (VREG_CODE > ceil_r) ? ceil_r : VREG_CODE;
  // reserved bits read as zero whatever was written
  assign rd_mux =
    (rsel == BDC_SEL_DET)   ? {pu_dis_r, det_dis_r, deb_cnt_r, sim_sel_r} :
    (rsel == BDC_SEL_CHG)   ? {tdis_r, 3'h0, hi_r, susp_r, 1'b0, battery_below_prequal_flag_r} :
    (rsel == BDC_SEL_VCEIL) ? {4'h0, ceil_r} :
    8'h00;

  // debounce channels; detection off forces the raw level low, so no removal is seen
  assign main_if.tick  = tick;
  assign main_if.raw   = q_r[3] & ~det_dis_r;
  assign main_if.count = deb_cnt_r;
  assign sim_if.tick   = tick;
  assign sim_if.raw    = q_r[3] & ~det_dis_r;
  assign sim_if.count  = `BDC_SIM_DEB_CYC;

  bdc_debounce #(.CNT_W(`BDC_CNT_W)) u_deb_main
  (
    .sys_clk (SYS_CLK),
    .rst     (RST),
    .ch      (main_if)
  );

  bdc_debounce #(.CNT_W(`BDC_CNT_W)) u_deb_sim
  (
    .sys_clk (SYS_CLK),
    .rst     (RST),
    .ch      (sim_if)
  );

  // register writes; reserved bits are dropped, low battery bit is status only
  always_ff @(posedge SYS_CLK)
  begin
    if (RST)
    begin
      sim_sel_r <= 1'b0;
      deb_cnt_r <= 5'h17;
      det_dis_r <= 1'b1;
      pu_dis_r  <= 1'b0;
      susp_r    <= 1'b0;
      hi_r      <= 1'b0;
      tdis_r    <= 1'b0;
      ceil_r    <= 4'hf;
    end
    else if (REG_WR && wsel == BDC_SEL_DET)
    begin
      sim_sel_r <= REG_WDATA[`BDC_DET_SIMSEL];
      deb_cnt_r <= REG_WDATA[`BDC_DET_CNT_MSB:`BDC_DET_CNT_LSB];
      det_dis_r <= REG_WDATA[`BDC_DET_DIS];
      pu_dis_r  <= REG_WDATA[`BDC_DET_PUDIS];
    end
    else if (REG_WR && wsel == BDC_SEL_CHG)
    begin
      susp_r    <= REG_WDATA[`BDC_CHG_SUSP];
      hi_r      <= REG_WDATA[`BDC_CHG_HI];
      tdis_r    <= REG_WDATA[`BDC_CHG_TDIS];
    end
    else if (REG_WR && wsel == BDC_SEL_VCEIL)
      ceil_r    <= REG_WDATA[`BDC_VCEIL_MSB:0];
  end

  // read data and status, registered
  always_ff @(posedge SYS_CLK)
  begin
    if (RST)
    begin
      REG_RDATA  <= 8'h00;
      REG_RVALID <= 1'b0;
      battery_below_prequal_flag_r  <= 1'b0;
    end
    else
    begin
      REG_RVALID <= REG_RD;
      battery_below_prequal_flag_r  <= battery_below_prequal_flag_nxt;
      if (REG_RD)
        REG_RDATA <= rd_mux;
    end
  end

  // removal and detection outputs
  always_ff @(posedge SYS_CLK)
  begin
    if (RST)
    begin
      BATTERY_REMOVAL_SIGNAL <= 1'b0;
      SIM_REMOVED <= 1'b0;
      DET_EN      <= 1'b0;
      PULLUP_EN   <= 1'b1;
    end
    else
    begin
      BATTERY_REMOVAL_SIGNAL <= main_if.removed;
      SIM_REMOVED <= sim_sel_r ? main_if.removed : sim_if.removed;
      DET_EN      <= ~det_dis_r;
      PULLUP_EN   <= ~pu_dis_r;
    end
  end

  // input limit, timer and termination voltage outputs
  always_ff @(posedge SYS_CLK)
  begin
    if (RST)
    begin
      DC_INPUT_ON    <= 1'b1;
      ILIM_500MA     <= 1'b0;
      ILIM_USE_FIELD <= 1'b0;
      ILIM_FIELD_OUT <= 6'h00;
      CHG_TIMER_EN   <= 1'b1;
      VTERM_EFF      <= 4'h0;
    end
    else
    begin
      DC_INPUT_ON    <= ~susp_r;
      ILIM_500MA     <= ~susp_r & ~ILIM_FIELD_SEL & hi_r;
      ILIM_USE_FIELD <= ~susp_r & ILIM_FIELD_SEL;
      ILIM_FIELD_OUT <= (~susp_r & ILIM_FIELD_SEL) ? ILIM_FIELD : 6'h00;
      CHG_TIMER_EN   <= ~tdis_r;
      VTERM_EFF      <= vclamp;
    end
  end

  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (RST);

  a_sim_fixed_path: assert property (!sim_sel_r |=> SIM_REMOVED == $past(sim_if.removed))
    else $error("sim removal not from fixed filter");
  a_sim_main_path: assert property (sim_sel_r |=> SIM_REMOVED == $past(main_if.removed))
    else $error("sim removal not equal to main removal");
  a_battery_removal_signal_out: assert property ($changed(main_if.removed) |=> BATTERY_REMOVAL_SIGNAL == $past(main_if.removed))
    else $error("battery removal output lags");
  a_det_gate_raw: assert property (det_dis_r |-> !main_if.raw && !sim_if.raw ##1 !DET_EN)
    else $error("detection disable ignored");
  a_pullup_ctrl: assert property ($changed(pu_dis_r) |=> PULLUP_EN != $past(pu_dis_r))
    else $error("pull-up enable wrong");
  a_battery_below_prequal_flag_flag: assert property (1'b1 |=> battery_below_prequal_flag_r == ($past(q_r[2]) && $past(q_r[1]) && !$past(q_r[0])))
    else $error("low battery flag wrong");
  a_suspend_all_off: assert property (susp_r |=> !DC_INPUT_ON && !ILIM_500MA && !ILIM_USE_FIELD && ILIM_FIELD_OUT == 6'h00)
    else $error("suspend did not disable input");
  a_ilim_fixed_sel: assert property (!susp_r && !ILIM_FIELD_SEL |=> ILIM_500MA == $past(hi_r) && !ILIM_USE_FIELD)
    else $error("fixed limit selection wrong");
  a_ilim_field_sel: assert property (!susp_r && ILIM_FIELD_SEL |=> !ILIM_500MA && ILIM_FIELD_OUT == $past(ILIM_FIELD))
    else $error("field limit selection wrong");
  a_timer_ctrl: assert property (tdis_r [*2] |=> !CHG_TIMER_EN)
    else $error("charge timer not disabled");
  a_vterm_clamp: assert property (1'b1 |=> VTERM_EFF <= $past(ceil_r) && VTERM_EFF <= $past(VREG_CODE))
    else $error("termination voltage above ceiling");
  a_rsvd_read_zero: assert property (REG_RD && rsel == BDC_SEL_VCEIL |=> REG_RVALID && REG_RDATA[7:4] == 4'h0)
    else $error("reserved bits read nonzero");

  c_main_removal: cover property ($rose(BATTERY_REMOVAL_SIGNAL));
  c_sim_fast_first: cover property (!sim_sel_r && SIM_REMOVED && !BATTERY_REMOVAL_SIGNAL);
  c_suspend_write: cover property (REG_WR && wsel == BDC_SEL_CHG && REG_WDATA[`BDC_CHG_SUSP]);
  c_vterm_clamped: cover property (VREG_CODE > ceil_r);

endmodule

// File: bdc_defs.svh
`ifndef BDC_DEFS_SVH
`define BDC_DEFS_SVH

// register offsets on the internal register port of the serial interface
`define BDC_OFS_DET        8'h3f
`define BDC_OFS_CHG        8'h40
`define BDC_OFS_VCEIL      8'h41

// reset values
`define BDC_RST_DET        8'h6e
`define BDC_RST_CHG        8'h00
`define BDC_RST_VCEIL      8'h0f

// battery detection register fields
`define BDC_DET_SIMSEL     0
`define BDC_DET_CNT_LSB    1
`define BDC_DET_CNT_MSB    5
`define BDC_DET_DIS        6
`define BDC_DET_PUDIS      7

// input charger register fields
`define BDC_CHG_LOWBAT     0
`define BDC_CHG_SUSP       2
`define BDC_CHG_HI         3
`define BDC_CHG_TDIS       7

// ceiling register field
`define BDC_VCEIL_MSB      3

// debounce timing: counter width, sim count in slow oscillator periods, clock rates in Hz
`define BDC_CNT_W          5
`define BDC_SIM_DEB_CYC    5'h03
`define BDC_OSC_HZ         100000
`define BDC_SYS_HZ         40000000

// number of pin inputs passed through the synchroniser
`define BDC_NPIN           5

`endif

// File: bdc_pkg.sv
package bdc_pkg;

  // one-hot register select from the address decoder
  typedef enum logic [3:0]
  {
    BDC_SEL_NONE  = 4'h1,
    BDC_SEL_DET   = 4'h2,
    BDC_SEL_CHG   = 4'h4,
    BDC_SEL_VCEIL = 4'h8
  } bdc_sel_e;

  typedef logic [7:0] bdc_byte_t;
  typedef logic [3:0] bdc_vcode_t;

endpackage

// File: bdc_deb_if.sv
`timescale 1ns/1ps

// carries one debounce channel between the register bank and its filter
interface bdc_deb_if #(parameter int W = 5);
  logic         tick;
  logic         raw;
  logic [W-1:0] count;
  logic         removed;

  modport deb (input tick, input raw, input count, output removed);
  modport ctl (output tick, output raw, output count, input removed);
endinterface

// File: bdc_debounce.sv
`timescale 1ns/1ps

// removal debounce: raw level must hold for more than count slow ticks
module bdc_debounce
  import bdc_pkg::*;
#(
  parameter int CNT_W = 5
)
(
  // clock and reset
  input  wire logic sys_clk,
  input  wire logic rst,
  // channel
  bdc_deb_if.deb    ch
);

  logic [CNT_W:0]   cnt_r;
  logic [CNT_W:0]   cnt_inc;
  logic             stable_r;
  logic             hit;

  // refuse counter widths the compare cannot serve, at elaboration
  if (CNT_W < 2 || CNT_W > 16)
  begin : g_bad_width
    $error("bdc_debounce: CNT_W out of range");
  end

  // counter is one bit wider so count+1 ticks fit; first tick is a partial period
  assign cnt_inc = cnt_r + {{CNT_W{1'b0}}, 1'b1};
  assign hit     = cnt_inc > {1'b0, ch.count};
  assign ch.removed = stable_r;

  // restart on any bounce back to the stable level
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      cnt_r    <= '0;
      stable_r <= 1'b0;
    end
    else if (ch.raw == stable_r)
      cnt_r    <= '0;
    else if (ch.tick && hit)
    begin
      stable_r <= ch.raw;
      cnt_r    <= '0;
    end
    else if (ch.tick)
      cnt_r    <= cnt_inc;
  end

  // level only moves on a tick after the full count
  a_deb_count_reached: assert property (@(posedge sys_clk) disable iff (rst)
    $changed(stable_r) |-> $past(ch.tick) && ($past(cnt_r) >= {1'b0, $past(ch.count)}))
    else $error("debounced level changed early");

endmodule

// File: bdc_host.sv
`timescale 1ns/1ps

// host side of the register port; idle lines show the inverse of the last value
module bdc_host
  import bdc_pkg::*;
(
  // clock
  input  wire logic      sys_clk,
  // register port
  output bdc_byte_t      reg_addr,
  output bdc_byte_t      reg_wdata,
  output logic           reg_wr,
  output logic           reg_rd,
  input  wire bdc_byte_t reg_rdata,
  input  wire logic      reg_rvalid
);
  // quiet bus at time zero
  initial
  begin
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
  end

  // one-cycle write strobe
  task automatic wr(input bdc_byte_t a, input bdc_byte_t d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
    reg_addr <= ~a;
    reg_wdata <= ~d;
  endtask

  // one-cycle read strobe, then bounded wait for the valid pulse
  task automatic rd(input bdc_byte_t a, output bdc_byte_t d, output bit ok);
    ok = 1'b0;
    d = 8'h00;
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    reg_addr <= ~a;
    for (int i = 0; i < 4 && !ok; i++)
    begin
      #1;
      if (reg_rvalid === 1'b1)
      begin
        d = reg_rdata;
        ok = 1'b1;
      end
      else
        @(posedge sys_clk);
    end
  endtask
endmodule

// File: battery_detect_charger_ctrl_regs_test.sv
`timescale 1ns/1ps
`include "bdc_defs.svh"

module battery_detect_charger_ctrl_regs_test
  import bdc_pkg::*;
;
  localparam int HALF = `BDC_SYS_HZ / `BDC_OSC_HZ / 2;
  localparam int PER = 2 * HALF;
  logic sys_clk = 1'b0, rst = 1'b1, osc = 1'b0;
  logic bat_abs = 1'b0, below = 1'b0, dcv = 1'b0, wcv = 1'b0, fsel = 1'b0;
  logic [5:0] fld = 6'h00;
  logic [3:0] vreg = 4'h9;
  bdc_byte_t addr, wdata, rdata;
  logic wr, rd, rvalid, bat_rem, sim_rem, det_en, pu_en, dc_on, i500, iuse, tmr_en;
  logic [5:0] fout;
  logic [3:0] vterm;
  int mismatches = 0, cmp_count = 0, oc = 0, tb, ts;

  // clock and free-running slow oscillator
  always #12.5 sys_clk = ~sys_clk;
  always @(posedge sys_clk)
  begin
    oc <= (oc == HALF - 1) ? 0 : oc + 1;
    if (oc == HALF - 1)
      osc <= ~osc;
  end

  bdc_host i_bdc_host (.sys_clk(sys_clk), .reg_addr(addr), .reg_wdata(wdata), .reg_wr(wr),
    .reg_rd(rd), .reg_rdata(rdata), .reg_rvalid(rvalid));
  bdc_regs i_bdc_regs (.SYS_CLK(sys_clk), .RST(rst), .REG_ADDR(addr), .REG_WDATA(wdata),
    .REG_WR(wr), .REG_RD(rd), .REG_RDATA(rdata), .REG_RVALID(rvalid), .OSC_100K(osc),
    .BAT_ABSENT(bat_abs), .MBATT_BELOW_PQ(below), .DC_VALID(dcv), .WC_VALID(wcv),
    .ILIM_FIELD_SEL(fsel), .ILIM_FIELD(fld), .VREG_CODE(vreg), .BATTERY_REMOVAL_SIGNAL(bat_rem),
    .SIM_REMOVED(sim_rem), .DET_EN(det_en), .PULLUP_EN(pu_en), .DC_INPUT_ON(dc_on),
    .ILIM_500MA(i500), .ILIM_USE_FIELD(iuse), .ILIM_FIELD_OUT(fout),
    .CHG_TIMER_EN(tmr_en), .VTERM_EFF(vterm));

  // value compare
  task automatic chk(input string nm, input bdc_byte_t exp, input bdc_byte_t got);
    cmp_count++;
    if (got !== exp)
    begin
      mismatches++;
      $display("unexpected %s: expected %h, seen %h", nm, exp, got);
    end
  endtask

  // delay compare, in system cycles
  task automatic chk_rng(input string nm, input int lo, input int hi, input int got);
    cmp_count++;
    if (got < lo || got > hi)
    begin
      mismatches++;
      $display("unexpected %s: expected %0d..%0d, seen %0d", nm, lo, hi, got);
    end
  endtask

  task automatic rdchk(input bdc_byte_t a, input bdc_byte_t exp);
    bdc_byte_t d;
    bit ok;
    i_bdc_host.rd(a, d, ok);
    chk("read valid", 8'h01, {7'h00, ok});
    chk("read data", exp, d);
  endtask

  // let outputs settle after a same-clock change
  task automatic settle();
    repeat (3) @(posedge sys_clk);
    #1;
  endtask

  // cycles until each removal output reaches lvl
  task automatic meas(input logic lvl);
    tb = -1;
    ts = -1;
    for (int i = 0; i < 2000; i++)
    begin
      @(posedge sys_clk);
      #1;
      if (tb < 0 && bat_rem === lvl) tb = i;
      if (ts < 0 && sim_rem === lvl) ts = i;
    end
  endtask

  task automatic wrap_up();
    $display("comparisons %0d, mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // cut a hang short
  initial
  begin
    #(25ns * 20000);
    mismatches++;
    wrap_up();
  end

  initial
  begin
    repeat (5) @(posedge sys_clk);
    rst <= 1'b0;
    settle();
    chk("det_en", 8'h00, det_en);
    chk("pullup", 8'h01, pu_en);
    chk("timer", 8'h01, tmr_en);
    rdchk(`BDC_OFS_DET, `BDC_RST_DET);
    rdchk(`BDC_OFS_CHG, `BDC_RST_CHG);
    rdchk(`BDC_OFS_VCEIL, `BDC_RST_VCEIL);
    i_bdc_host.wr(8'h42, 8'hff);
    rdchk(8'h42, 8'h00);
    $display("test reset done");
    // suspend, fixed limits, field select, timer
    i_bdc_host.wr(`BDC_OFS_CHG, 8'hfe);
    rdchk(`BDC_OFS_CHG, 8'h8c);
    settle();
    chk("dc_on", 8'h00, dc_on);
    chk("timer", 8'h00, tmr_en);
    i_bdc_host.wr(`BDC_OFS_CHG, 8'h08);
    settle();
    chk("lim", 8'h0d, {4'h0, dc_on, i500, iuse, tmr_en});
    @(posedge sys_clk);
    fsel <= 1'b1;
    fld <= 6'h2a;
    settle();
    chk("lim", 8'h6a, {i500, iuse, fout});
    @(posedge sys_clk);
    fsel <= 1'b0;
    i_bdc_host.wr(`BDC_OFS_CHG, 8'h00);
    settle();
    chk("lim", 8'h04, {5'h00, dc_on, i500, iuse});
    chk("field", 8'h00, {2'h0, fout});
    $display("test input limit done");
    // low battery over all pin combinations
    for (int i = 0; i < 8; i++)
    begin
      @(posedge sys_clk);
      {below, dcv, wcv} <= i[2:0];
      repeat (8) @(posedge sys_clk);
      rdchk(`BDC_OFS_CHG, {7'h00, i == 6});
    end
    $display("test low battery done");
    i_bdc_host.wr(`BDC_OFS_VCEIL, 8'hf5);
    rdchk(`BDC_OFS_VCEIL, 8'h05);
    settle();
    chk("vterm", 8'h05, vterm);
    @(posedge sys_clk);
    vreg <= 4'h3;
    settle();
    chk("vterm", 8'h03, vterm);
    $display("test ceiling done");
    // removal debounce, count 2, fixed sim filter then sim select 1
    i_bdc_host.wr(`BDC_OFS_DET, 8'h04);
    settle();
    chk("det", 8'h03, {6'h00, det_en, pu_en});
    @(posedge sys_clk);
    bat_abs <= 1'b1;
    meas(1'b1);
    chk_rng("main delay", 2 * PER, 3 * PER + 10, tb);
    chk_rng("sim delay", 3 * PER, 4 * PER + 10, ts);
    i_bdc_host.wr(`BDC_OFS_DET, 8'h05);
    bat_abs <= 1'b0;
    meas(1'b0);
    chk_rng("main delay", 2 * PER, 3 * PER + 10, tb);
    chk_rng("sim follow", tb, tb, ts);
    $display("test debounce done");
    i_bdc_host.wr(`BDC_OFS_DET, 8'hc4);
    settle();
    chk("det", 8'h00, {6'h00, det_en, pu_en});
    @(posedge sys_clk);
    bat_abs <= 1'b1;
    repeat (4 * PER) @(posedge sys_clk);
    #1;
    chk("removed", 8'h00, bat_rem);
    chk("sim removed", 8'h00, sim_rem);
    $display("test detect off done");
    wrap_up();
  end
endmodule
